//--- design/mmt_pkg.sv
/*
 Package for the multi-mode timer: register offsets, field positions,
 reset values and mode/function encodings.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package mmt_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] MMT_CTRL0_OFS  = 8'h00;
  localparam logic [7:0] MMT_CTRL1_OFS  = 8'h04;
  localparam logic [7:0] MMT_CNTL_OFS   = 8'h08;
  localparam logic [7:0] MMT_CNTH_OFS   = 8'h0C;
  localparam logic [7:0] MMT_CMPAL_OFS  = 8'h10;
  localparam logic [7:0] MMT_CMPAH_OFS  = 8'h14;
  localparam logic [7:0] MMT_FLAGS_OFS  = 8'h18;

  // ==========================================================================
  // Control 0 fields: run bit, clock select, period compare
  localparam int MMT_RUN_BIT    = 3;
  localparam int MMT_CKSEL_LSB  = 4;
  localparam int MMT_PER_LSB    = 0;

  // Control 1 fields
  localparam int MMT_MODE_LSB   = 6;
  localparam int MMT_FUNC_LSB   = 4;
  localparam int MMT_OINIT_BIT  = 3;
  localparam int MMT_OINV_BIT   = 2;
  localparam int MMT_SWAP_BIT   = 1;
  localparam int MMT_CCLR_BIT   = 0;

  // Flag register fields
  localparam int MMT_FA_BIT     = 0;
  localparam int MMT_FP_BIT     = 1;

  localparam logic [7:0] MMT_CTRL_RST = 8'h00;
  localparam logic [9:0] MMT_CMPA_RST = 10'h000;
  localparam logic [2:0] MMT_PER_ZERO = 3'h0;

  // Clock select: codes 6 and 7 take the external clock pin edges
  localparam logic [2:0] MMT_CK_EXT_RISE = 3'h6;
  localparam logic [2:0] MMT_CK_EXT_FALL = 3'h7;

  typedef enum logic [1:0] {
    MMT_MODE_CMP   = 2'b00,
    MMT_MODE_CAP   = 2'b01,
    MMT_MODE_PWM   = 2'b10,
    MMT_MODE_TIMER = 2'b11
  } mmt_mode_e;

  // Pin function codes
  localparam logic [1:0] MMT_FN_0 = 2'b00;
  localparam logic [1:0] MMT_FN_1 = 2'b01;
  localparam logic [1:0] MMT_FN_2 = 2'b10;
  localparam logic [1:0] MMT_FN_3 = 2'b11;

endpackage

//--- design/mmt_timer.sv
/*
 Multi-mode 10-bit timer with APB register access.
 Assumes an APB master on the same clock; external clock and capture pins
 are asynchronous and synchronised here.
*/
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps

module mmt_timer
  import mmt_pkg::*;
#(
  parameter int CNT_W    = 10,
  parameter int PER_W    = 3,
  parameter int PRESCALE = 4
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_clock_pin,
  input  wire logic        capture_input_pin,
  output logic             timer_out,
  output logic             timer_out_en,
  output logic             timer_irq_pulse
);

  // ==========================================================================
  // Clock select field width
  localparam int CKSEL_W = 3;

  // ==========================================================================
  // Registers
  logic [7:0]       ctrl0_reg;
  logic [7:0]       ctrl1_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cmpa_reg;
  logic             flag_a_reg;
  logic             flag_p_reg;
  logic             run_d_reg;
  logic             pin_reg;
  logic [PER_W-1:0] per_reg;
  logic [15:0]      pre_reg;
  logic [1:0]       eck_sync_reg;
  logic             eck_d_reg;
  logic [1:0]       cap_sync_reg;
  logic             cap_d_reg;

  mmt_mode_e        mode;
  logic [1:0]       func;
  logic             run;
  logic             run_rise;
  logic             tick;
  logic             match_a;
  logic             match_p;
  logic             cnt_clear;
  logic             cmp_like;
  logic             pulse_mode;
  logic             eck_edge;
  logic             cap_edge;
  logic             capture;
  logic             pwm_active;
  logic [CNT_W:0]   duty_v;
  logic [CNT_W:0]   period_v;
  logic             wr;
  logic             rd_ok;
  logic             clr_a;
  logic             clr_p;
  logic [CKSEL_W-1:0] cksel;
  logic             ext_clk_sel;

  function automatic logic [CNT_W:0] per_to_count(input logic [PER_W-1:0] p);
    logic [CNT_W:0] r;
    r = {1'b0, p, {(CNT_W-PER_W){1'b0}}};
    if (p == MMT_PER_ZERO) begin
      r = {1'b1, {CNT_W{1'b0}}};
    end
    return r;
  endfunction

  // Value the counter would step to next, one bit wider so that the end
  // of a full 1024-count period shows as 1024 and not as zero
  function automatic logic [CNT_W:0] next_count(input logic [CNT_W-1:0] c);
    return {1'b0, c} + {{CNT_W{1'b0}}, 1'b1};
  endfunction

  assign mode       = mmt_mode_e'(ctrl1_reg[MMT_MODE_LSB +: 2]);
  assign func       = ctrl1_reg[MMT_FUNC_LSB +: 2];
  assign run        = ctrl0_reg[MMT_RUN_BIT];
  assign per_reg    = ctrl0_reg[MMT_PER_LSB +: PER_W];
  assign run_rise   = run & ~run_d_reg;
  assign cmp_like   = (mode == MMT_MODE_CMP) || (mode == MMT_MODE_TIMER);
  assign pulse_mode = (mode == MMT_MODE_PWM) && (func == MMT_FN_3);
  assign wr         = psel & penable & pwrite;
  assign cksel      = ctrl0_reg[MMT_CKSEL_LSB +: CKSEL_W];
  assign ext_clk_sel = (cksel == MMT_CK_EXT_RISE) || (cksel == MMT_CK_EXT_FALL);

  // ==========================================================================
  // Timer clock: prescaler tick or external pin edge
  // Two-stage synchronisers for the asynchronous pins
  always_ff @(posedge clock) begin
    if (srst) begin
      eck_sync_reg <= 2'b00;
      eck_d_reg    <= 1'b0;
      cap_sync_reg <= 2'b00;
      cap_d_reg    <= 1'b0;
      run_d_reg    <= 1'b0;
    end else begin
      eck_sync_reg <= {eck_sync_reg[0], external_clock_pin};
      eck_d_reg    <= eck_sync_reg[1];
      cap_sync_reg <= {cap_sync_reg[0], capture_input_pin};
      cap_d_reg    <= cap_sync_reg[1];
      run_d_reg    <= run;
    end
  end

  assign eck_edge = (cksel == MMT_CK_EXT_FALL)
                  ? (eck_d_reg & ~eck_sync_reg[1]) : (~eck_d_reg & eck_sync_reg[1]);

  // Prescaler: one tick every PRESCALE clocks
  always_ff @(posedge clock) begin
    if (srst || pre_reg == 16'(PRESCALE - 1)) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_reg + 16'h0001;
    end
  end

  always_comb begin
    tick = (pre_reg == 16'(PRESCALE - 1));
    if (ext_clk_sel) begin
      tick = eck_edge;
    end
  end

  // ==========================================================================
  // Comparators
  // A match is the tick on which the counter would reach the compare value;
  // clearing on it replaces that step, so a period of N ticks counts 0..N-1
  assign match_a = tick & run & (next_count(cnt_reg) == {1'b0, cmpa_reg});
  // Period code sets counter bits 9..7; code zero stands for the full range
  assign match_p = tick & run & (next_count(cnt_reg) == per_to_count(per_reg));

  always_comb begin
    cnt_clear = 1'b0;
    if (cmp_like) begin
      if (ctrl1_reg[MMT_CCLR_BIT]) begin
        cnt_clear = match_a;
      end else begin
        // Period code zero matches at the top count: overflow clear
        cnt_clear = match_p;
      end
    end else if (mode == MMT_MODE_PWM && !pulse_mode) begin
      cnt_clear = ctrl1_reg[MMT_SWAP_BIT] ? match_a : match_p;
    end else if (mode == MMT_MODE_CAP) begin
      cnt_clear = (per_reg == MMT_PER_ZERO) ? 1'b0 : match_p;
    end
  end

  // ==========================================================================
  // Counter
  // Run rise restarts from zero; run low holds the residual count
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg <= '0;
    end else if (run_rise) begin
      cnt_reg <= '0;
    end else if (run && tick) begin
      cnt_reg <= cnt_clear ? '0 : cnt_reg + 1'b1;
    end
  end

  // ==========================================================================
  // Capture edge select
  // Edges come from the synchronised copy, two cycles behind the pin
  always_comb begin
    unique case (func)
      MMT_FN_0: cap_edge = ~cap_d_reg & cap_sync_reg[1];
      MMT_FN_1: cap_edge = cap_d_reg & ~cap_sync_reg[1];
      MMT_FN_2: cap_edge = cap_d_reg ^ cap_sync_reg[1];
      MMT_FN_3: cap_edge = 1'b0;
    endcase
  end
  // Capture only while running in capture mode
  assign capture = (mode == MMT_MODE_CAP) & run & cap_edge;

  // ==========================================================================
  // PWM level: duty and period chosen by the swap bit
  always_comb begin
    if (ctrl1_reg[MMT_SWAP_BIT]) begin
      duty_v   = per_to_count(per_reg);
      period_v = {1'b0, cmpa_reg};
    end else begin
      duty_v   = {1'b0, cmpa_reg};
      period_v = per_to_count(per_reg);
    end
    // Full duty once the duty value reaches the period
    pwm_active = (duty_v >= period_v) || ({1'b0, cnt_reg} < duty_v);
  end

  // ==========================================================================
  // APB and software registers
  assign clr_a = wr && paddr == MMT_FLAGS_OFS && pwdata[MMT_FA_BIT];
  assign clr_p = wr && paddr == MMT_FLAGS_OFS && pwdata[MMT_FP_BIT];

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl0_reg <= MMT_CTRL_RST;
      ctrl1_reg <= MMT_CTRL_RST;
    end else begin
      if (wr && paddr == MMT_CTRL1_OFS) begin
        ctrl1_reg <= pwdata[7:0];
      end
      if (wr && paddr == MMT_CTRL0_OFS) begin
        ctrl0_reg <= pwdata[7:0];
      // Pin edge starts a pulse only while the counter is idle
      end else if (pulse_mode && !run && eck_edge) begin
        ctrl0_reg[MMT_RUN_BIT] <= 1'b1;
      end else if (pulse_mode && match_a) begin
        ctrl0_reg[MMT_RUN_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cmpa_reg <= MMT_CMPA_RST;
    end else if (capture) begin
      // A capture wins over a software write in the same cycle
      cmpa_reg <= cnt_reg;
    end else if (wr && paddr == MMT_CMPAL_OFS) begin
      cmpa_reg[7:0] <= pwdata[7:0];
    end else if (wr && paddr == MMT_CMPAH_OFS) begin
      cmpa_reg[CNT_W-1:8] <= pwdata[CNT_W-9:0];
    end
  end

  // Set wins over a same-cycle software clear
  always_ff @(posedge clock) begin
    if (srst) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      if (match_a || capture) begin
        flag_a_reg <= 1'b1;
      end else if (clr_a) begin
        flag_a_reg <= 1'b0;
      end
      if (match_p && !(cmp_like && ctrl1_reg[MMT_CCLR_BIT]) && !pulse_mode) begin
        flag_p_reg <= 1'b1;
      end else if (clr_p) begin
        flag_p_reg <= 1'b0;
      end
    end
  end

  // One-cycle event for the interrupt logic outside the block
  always_ff @(posedge clock) begin
    if (srst) begin
      timer_irq_pulse <= 1'b0;
    end else begin
      timer_irq_pulse <= (match_a && !(mode == MMT_MODE_CAP))
                       || capture
                       || (match_p && mode == MMT_MODE_CAP);
    end
  end

  // Unmapped addresses answer with an error and read as zero
  always_comb begin
    rd_ok = 1'b1;
    unique case (paddr)
      MMT_CTRL0_OFS, MMT_CTRL1_OFS, MMT_CNTL_OFS, MMT_CNTH_OFS,
      MMT_CMPAL_OFS, MMT_CMPAH_OFS, MMT_FLAGS_OFS: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read data is taken in the setup cycle so that it stands with pready
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          MMT_CTRL0_OFS: prdata[7:0] <= ctrl0_reg;
          MMT_CTRL1_OFS: prdata[7:0] <= ctrl1_reg;
          MMT_CNTL_OFS:  prdata[7:0] <= cnt_reg[7:0];
          MMT_CNTH_OFS:  prdata[CNT_W-9:0] <= cnt_reg[CNT_W-1:8];
          MMT_CMPAL_OFS: prdata[7:0] <= cmpa_reg[7:0];
          MMT_CMPAH_OFS: prdata[CNT_W-9:0] <= cmpa_reg[CNT_W-1:8];
          MMT_FLAGS_OFS: prdata[1:0] <= {flag_p_reg, flag_a_reg};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Output pin
  // Level before the invert; timer_out follows one cycle later
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_reg <= 1'b0;
    end else if (cmp_like) begin
      if (run_rise) begin
        pin_reg <= ctrl1_reg[MMT_OINIT_BIT];
      end else if (match_a) begin
        unique case (func)
          MMT_FN_0: pin_reg <= pin_reg;
          MMT_FN_1: pin_reg <= 1'b0;
          MMT_FN_2: pin_reg <= 1'b1;
          MMT_FN_3: pin_reg <= ~pin_reg;
        endcase
      end
    end else if (mode == MMT_MODE_PWM) begin
      unique case (func)
        MMT_FN_0: pin_reg <= ~ctrl1_reg[MMT_OINIT_BIT];
        MMT_FN_1: pin_reg <= ctrl1_reg[MMT_OINIT_BIT];
        MMT_FN_2: pin_reg <= (run && pwm_active) == ctrl1_reg[MMT_OINIT_BIT];
        MMT_FN_3: pin_reg <= (run && !(match_a)) == ctrl1_reg[MMT_OINIT_BIT];
      endcase
    end else begin
      pin_reg <= ~ctrl1_reg[MMT_OINIT_BIT];
    end
  end

  // Timer and capture modes leave the pin to other functions
  always_ff @(posedge clock) begin
    if (srst) begin
      timer_out    <= 1'b0;
      timer_out_en <= 1'b0;
    end else begin
      timer_out    <= pin_reg ^ ctrl1_reg[MMT_OINV_BIT];
      timer_out_en <= (mode == MMT_MODE_CMP) || (mode == MMT_MODE_PWM);
    end
  end

endmodule

//--- testbench/mmt_timer_assertions.sv
/* Checker for mmt_timer: APB answer timing, error answers, pin enable.
   Assumes it is bound to mmt_timer and sees only its ports. */
`timescale 1ns/1ps
module mmt_timer_assertions
  import mmt_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        external_clock_pin,
  input wire logic        capture_input_pin,
  input wire logic        timer_out,
  input wire logic        timer_out_en,
  input wire logic        timer_irq_pulse
);
  // ==========
  // Shadow of the mode field
  logic [1:0] mode_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= 2'b00;
    end else if (psel && penable && pwrite && pready && paddr == MMT_CTRL1_OFS) begin
      mode_reg <= pwdata[7:6];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ==========
  // Properties
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_pulse;
    pready |-> psel && penable ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready misplaced");
  property p_err_unmapped;
    pready && !pwrite && paddr > MMT_FLAGS_OFS |-> pslverr && prdata == 32'h0;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped read");
  property p_err_mapped;
    pready && paddr <= MMT_FLAGS_OFS && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped error");
  property p_hi_bytes;
    pready && !pwrite && (paddr == MMT_CMPAH_OFS || paddr == MMT_CNTH_OFS)
      |-> prdata[31:2] == 30'h0;
  endproperty
  a_hi_bytes: assert property (p_hi_bytes) else $error("high byte bits");
  property p_en_mode;
    $stable(mode_reg) [*3] |-> timer_out_en == !mode_reg[0];
  endproperty
  a_en_mode: assert property (p_en_mode) else $error("pin enable");
  property p_irq_pulse;
    timer_irq_pulse |=> !timer_irq_pulse;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_reset_out;
    $fell(srst) |-> !timer_out && !timer_out_en && !pready && !timer_irq_pulse;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs after reset");
endmodule

bind mmt_timer mmt_timer_assertions mmt_timer_assertions_inst (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_clock_pin(external_clock_pin), .capture_input_pin(capture_input_pin),
  .timer_out(timer_out), .timer_out_en(timer_out_en), .timer_irq_pulse(timer_irq_pulse));

//--- testbench/mmt_pin_model.sv
/* Pin-side partner: drives the external clock and capture inputs and
   counts clock cycles with the output pin high.
   Assumes set_pins is called right after a clock edge. */
`timescale 1ns/1ps
module mmt_pin_model (
  input  wire logic clock,
  input  wire logic timer_out,
  output logic      ext_pin,
  output logic      cap_pin,
  output int        hi_cnt
);
  // ==========
  // Pin drive and high-time count
  initial begin
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    hi_cnt  = 0;
  end
  always @(posedge clock) begin
    if (timer_out === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end
  end
  task automatic set_pins(input logic e, input logic c);
    @(posedge clock);
    ext_pin <= e;
    cap_pin <= c;
  endtask
endmodule

//--- testbench/mmt_timer_tb.sv
/* Bench for mmt_timer: APB tasks, one task per scenario, verdict.
   Assumes the pin model and the bound checker are compiled before it. */
`timescale 1ns/1ps
module mmt_timer_tb;
  import mmt_pkg::*;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, h;
  logic        pready, pslverr, err, ext_pin, cap_pin, timer_out, timer_out_en, timer_irq_pulse;
  int          hi_cnt, i0;
  int          n_irq = 0;
  int          n_fail = 0;
  int          checks = 0;
  always #50 clock = ~clock;
  always @(posedge clock) if (timer_irq_pulse === 1'b1) n_irq <= n_irq + 1;
  mmt_timer #(.PRESCALE(1)) mmt_timer_inst (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clock_pin(ext_pin), .capture_input_pin(cap_pin), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .timer_irq_pulse(timer_irq_pulse));
  mmt_pin_model mmt_pin_model_inst (.clock(clock), .timer_out(timer_out),
    .ext_pin(ext_pin), .cap_pin(cap_pin), .hi_cnt(hi_cnt));
  // ==========
  // Common tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_a(input logic [9:0] v);
    apb(1, MMT_CMPAL_OFS, {24'h0, v[7:0]});
    apb(1, MMT_CMPAH_OFS, {30'h0, v[9:8]});
  endtask
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    apb(0, MMT_CTRL1_OFS, 0);
    chk(q, 32'h0);
    apb(1, MMT_CMPAH_OFS, 32'hFF);
    apb(0, MMT_CMPAH_OFS, 0);
    chk(q, 32'h3);
    apb(0, 8'h1C, 0);
    chk(q, 32'h0);
    chk(err, 1);
  endtask
  task automatic t_cmp();
    logic [1:0] f;
    logic       o;
    for (int i = 0; i < 4; i++) begin
      f = 2'(i);
      o = (f != 2'b10);
      apb(1, MMT_CTRL0_OFS, 0);
      apb(1, MMT_CTRL1_OFS, {26'h0, f, o, 3'b001});
      set_a(10'd20);
      apb(1, MMT_FLAGS_OFS, 3);
      apb(1, MMT_CTRL0_OFS, 32'h8);
      waitc(4);
      chk(timer_out, o);
      chk(timer_out_en, 1);
      waitc(30);
      chk(timer_out, !f[0]);
      apb(0, MMT_FLAGS_OFS, 0);
      chk(q, 32'h1);
    end
  endtask
  task automatic t_mode();
    for (int i = 0; i < 2; i++) begin
      apb(1, MMT_CTRL0_OFS, 0);
      apb(1, MMT_CTRL1_OFS, i ? 32'hC0 : 32'h00);
      apb(1, MMT_FLAGS_OFS, 3);
      apb(1, MMT_CTRL0_OFS, 32'h9);
      waitc(300);
      chk(timer_out_en, i ? 0 : 1);
      apb(0, MMT_FLAGS_OFS, 0);
      chk(q, 32'h3);
      apb(0, MMT_CNTH_OFS, 0);
      chk(q, 32'h0);
    end
  endtask
  task automatic t_pwm();
    logic [7:0] c1 [4] = '{8'hA9, 8'hA8, 8'h98, 8'h88};
    logic [9:0] av [4] = '{10'd32, 10'd200, 10'd32, 10'd32};
    int         ex [4] = '{64, 256, 256, 0};
    for (int i = 0; i < 4; i++) begin
      apb(1, MMT_CTRL0_OFS, 0);
      apb(1, MMT_CTRL1_OFS, {24'h0, c1[i]});
      set_a(av[i]);
      apb(1, MMT_FLAGS_OFS, 3);
      apb(1, MMT_CTRL0_OFS, 32'h9);
      waitc(10);
      i0 = hi_cnt;
      waitc(256);
      chk(32'(hi_cnt - i0), 32'(ex[i]));
      apb(0, MMT_FLAGS_OFS, 0);
      chk(q, av[i] < 128 ? 32'h3 : 32'h2);
    end
  endtask
  task automatic t_pulse();
    apb(1, MMT_CTRL0_OFS, 0);
    apb(1, MMT_CTRL1_OFS, 32'hB8);
    set_a(10'd40);
    apb(1, MMT_FLAGS_OFS, 3);
    i0 = n_irq;
    mmt_pin_model_inst.set_pins(1, 0);
    mmt_pin_model_inst.set_pins(0, 0);
    waitc(6);
    chk(timer_out, 1);
    apb(0, MMT_CTRL0_OFS, 0);
    chk(q, 32'h8);
    waitc(60);
    chk(timer_out, 0);
    apb(0, MMT_CTRL0_OFS, 0);
    chk(q, 32'h0);
    apb(0, MMT_FLAGS_OFS, 0);
    chk(q & 32'h1, 32'h1);
    chk(32'(n_irq - i0), 1);
    apb(0, MMT_CNTL_OFS, 0);
    h = q;
    waitc(5);
    apb(0, MMT_CNTL_OFS, 0);
    chk(q, h);
  endtask
  task automatic t_cap();
    int ex [4] = '{1, 1, 2, 0};
    apb(1, MMT_CTRL0_OFS, 0);
    apb(1, MMT_CTRL1_OFS, 32'h40);
    apb(1, MMT_CTRL0_OFS, 32'h8);
    waitc(50);
    apb(0, MMT_CNTL_OFS, 0);
    h = q;
    mmt_pin_model_inst.set_pins(0, 1);
    mmt_pin_model_inst.set_pins(0, 0);
    waitc(6);
    apb(0, MMT_CMPAL_OFS, 0);
    chk(32'(q > h && q < h + 20), 1);
    for (int f = 0; f < 4; f++) begin
      apb(1, MMT_CTRL1_OFS, 32'(32'h40 | (f << 4)));
      i0 = n_irq;
      mmt_pin_model_inst.set_pins(0, 1);
      waitc(10);
      mmt_pin_model_inst.set_pins(0, 0);
      waitc(10);
      chk(32'(n_irq - i0), 32'(ex[f]));
    end
    apb(1, MMT_CTRL0_OFS, 0);
    apb(0, MMT_CNTL_OFS, 0);
    h = q;
    waitc(10);
    apb(0, MMT_CNTL_OFS, 0);
    chk(q, h);
    apb(1, MMT_CTRL0_OFS, 32'h8);
    apb(0, MMT_CNTL_OFS, 0);
    chk(32'(q < 10), 1);
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_cmp();
    t_mode();
    t_pwm();
    t_pulse();
    t_cap();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    final_report();
  end
endmodule
